// ==== rtl/fpim_pkg.sv ====
package fpim_pkg;
  typedef enum logic [1:0] {M_SLEEP, M_STBY, M_RX, M_TX} fpim_mode_t;
  typedef enum logic [2:0] {TX_IDLE, TX_PRE, TX_SYNC, TX_PAY, TX_END} fpim_tx_t;

  localparam int         BYTE_W        = 8;
  localparam int         FIFO_AW       = 6;
  localparam int         FIFO_DEPTH    = 64;
  localparam int         STAGE_AW      = 2;
  localparam int         STAGE_DEPTH   = 4;
  localparam logic [2:0] STAGE_LIMIT   = 3'h4;
  localparam int         SIZE_SHIFT    = 4;
  localparam logic [1:0] SEL_A         = 2'h1;
  localparam logic [1:0] SEL_B         = 2'h2;
  localparam logic [1:0] SEL_C         = 2'h3;
  localparam logic [7:0] PREAMBLE_BYTE = 8'hAA;
  localparam logic [7:0] FIX_MIN_LEN   = 8'h01;
  localparam logic [7:0] VAR_MIN_LEN   = 8'h02;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [7:0] PRE_COUNT_DEF = 8'h03;
endpackage : fpim_pkg

// ==== rtl/fpim_fifo_if.sv ====
`timescale 1ns/10ps
interface fpim_fifo_if #(
  parameter int W  = 8,
  parameter int AW = 6
);
  logic          wr_valid;
  logic          wr_ready;
  logic [W-1:0]  wr_data;
  logic          rd_valid;
  logic          rd_ready;
  logic [W-1:0]  rd_data;
  logic [AW:0]   level;

  modport store (input wr_valid, wr_data, rd_ready,
                 output wr_ready, rd_valid, rd_data, level);
  modport user  (output wr_valid, wr_data, rd_ready,
                 input wr_ready, rd_valid, rd_data, level);
endinterface : fpim_fifo_if

// ==== rtl/fpim_sync.sv ====
`timescale 1ns/10ps
module fpim_sync #(
  parameter int W = 1
) (
  input  wire logic         clk_in,
  input  wire logic         rstn_in,
  input  wire logic [W-1:0] d_in,
  output logic      [W-1:0] q_out
);
  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;
  // A bit moves only once the second and third stages agree
  wire  [W-1:0] agree = ~(s2_q ^ s3_q);

  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      s1_q  <= '0;
      s2_q  <= '0;
      s3_q  <= '0;
      q_out <= '0;
    end else begin
      s1_q  <= d_in;
      s2_q  <= s1_q;
      s3_q  <= s2_q;
      q_out <= (agree & s2_q) | (~agree & q_out);
    end
  end
endmodule : fpim_sync

// ==== rtl/fpim_fifo.sv ====
`timescale 1ns/10ps
module fpim_fifo #(
  parameter int W     = 8,
  parameter int DEPTH = 64,
  parameter int AW    = 6
) (
  input  wire logic        clk_in,
  input  wire logic        rstn_in,
  input  wire logic [AW:0] limit_in,
  fpim_fifo_if.store       f
);
  logic [W-1:0]  mem [DEPTH];
  logic [AW-1:0] wp_q;
  logic [AW-1:0] rp_q;
  logic [AW:0]   cnt_q;
  logic [W-1:0]  rd_q;

  // Full follows the selected size, so a smaller size simply stops writes earlier
  assign f.wr_ready = cnt_q < limit_in;
  assign f.rd_valid = cnt_q != '0;
  assign f.rd_data  = rd_q;
  assign f.level    = cnt_q;
  wire push = f.wr_valid & f.wr_ready;
  wire pop  = f.rd_ready & f.rd_valid;

  always_ff @(posedge clk_in) begin
    if (push) begin
      mem[wp_q] <= f.wr_data;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      wp_q  <= '0;
      rp_q  <= '0;
      cnt_q <= '0;
      rd_q  <= '0;
    end else begin
      wp_q  <= wp_q + AW'(push);
      rp_q  <= rp_q + AW'(pop);
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
      if (pop) begin
        rd_q <= mem[rp_q];
      end
    end
  end
endmodule : fpim_fifo

// ==== rtl/fpim_top.sv ====
`timescale 1ns/10ps
module fpim_top
  import fpim_pkg::*;
#(
  parameter logic [7:0] PRE_COUNT = PRE_COUNT_DEF
) (
  input  wire logic       core_clk_in,
  input  wire logic       rstn_in,
  input  wire fpim_mode_t mode_in,
  input  wire logic       packet_mode_in,
  input  wire logic       sync_on_in,
  input  wire logic [1:0] fifo_size_in,
  input  wire logic [5:0] fifo_thresh_in,
  input  wire logic [1:0] irq0_sel_in,
  input  wire logic [1:0] irq1_sel_in,
  input  wire logic       tx_irq1_sel_in,
  input  wire logic       tx_start_sel_in,
  input  wire logic       fill_method_in,
  input  wire logic       fill_in,
  input  wire logic       pkt_var_len_in,
  input  wire logic [7:0] payload_len_in,
  input  wire logic [7:0] sync_pattern_in,
  input  wire logic       overrun_clr_in,
  input  wire logic       link_clk_in,
  input  wire logic       rx_data_in,
  input  wire logic       rssi_in,
  input  wire logic       wr_valid_in,
  input  wire logic [7:0] wr_data_in,
  output logic            wr_ready_out,
  input  wire logic       rd_req_in,
  output logic            rd_valid_out,
  output logic      [7:0] rd_data_out,
  output logic            tx_data_out,
  output logic            irq0_out,
  output logic            irq1_out,
  output logic            overrun_out,
  output logic            sync_en_out,
  output logic            bitsync_en_out
);
  function automatic logic irq_pick(input logic [1:0] sel, input logic a,
                                    input logic b, input logic c);
    irq_pick = (sel == SEL_A) ? a : (sel == SEL_B) ? b : (sel == SEL_C) ? c : 1'b0;
  endfunction : irq_pick

  // Adds in nine bits and clamps after, so a length byte of 0xFF cannot wrap to zero
  function automatic logic [7:0] len_clamp(input logic [7:0] n, input logic inc,
                                           input logic [7:0] lo, input logic [6:0] hi);
    logic [8:0] s;
    s = {1'b0, n} + {8'h00, inc};
    len_clamp = (s < {1'b0, lo}) ? lo : (s > {2'b00, hi}) ? {1'b0, hi} : s[7:0];
  endfunction : len_clamp

  fpim_fifo_if #(.W(BYTE_W), .AW(FIFO_AW))  mf ();
  fpim_fifo_if #(.W(BYTE_W), .AW(STAGE_AW)) sf ();

  logic [2:0] ls;
  logic       lclk_q;
  logic [7:0] rx_sr_q;
  logic [2:0] rx_bits_q;
  logic       sync_seen_q;
  logic [7:0] rx_cnt_q;
  logic [7:0] rx_tgt_q;
  logic       pend_q;
  fpim_tx_t   phase_q;
  logic [7:0] pre_cnt_q;
  logic [7:0] tx_tgt_q;
  logic [7:0] tx_cnt_q;
  logic [7:0] tx_sr_q;
  logic [3:0] tx_bits_q;
  logic       pop_pend_q;
  logic       tx_done_q;

  fpim_sync #(.W(3)) u_sync (
    .clk_in  (core_clk_in),
    .rstn_in (rstn_in),
    .d_in    ({rssi_in, rx_data_in, link_clk_in}),
    .q_out   (ls)
  );

  wire       in_rx    = mode_in == M_RX;
  wire       in_tx    = mode_in == M_TX;
  wire       in_stby  = mode_in == M_STBY;
  wire       bit_tick = ls[0] & ~lclk_q;
  wire [6:0] lim      = 7'({1'b0, fifo_size_in} + 3'h1) << SIZE_SHIFT;
  wire       nempty   = mf.rd_valid;
  wire       full     = ~mf.wr_ready;
  wire       thr      = mf.level >= {1'b0, fifo_thresh_in};
  wire       sync_en  = sync_on_in | packet_mode_in;

  // Receive side
  wire [7:0] rx_next    = {rx_sr_q[6:0], ls[1]};
  wire       rx_tick    = bit_tick & in_rx;
  wire       sync_hit   = rx_tick & sync_en & ~sync_seen_q & (rx_next == sync_pattern_in);
  wire       pkt_rx_end = packet_mode_in & (rx_cnt_q != 8'h00) & (rx_cnt_q >= rx_tgt_q);
  wire       fill_gate  = fill_method_in ? fill_in : sync_seen_q;
  wire       capturing  = packet_mode_in ? (sync_seen_q & ~pkt_rx_end) : fill_gate;
  wire       byte_done  = rx_tick & capturing & ~sync_hit & (rx_bits_q == 3'h7);
  wire       rx_push    = byte_done & mf.wr_ready;
  wire       rx_ovr     = byte_done & ~mf.wr_ready;
  wire       thr_src    = thr & ~(in_rx & ~fill_method_in & ~sync_seen_q);

  // Host side of the byte store
  wire wr_ok    = in_tx | (in_stby & packet_mode_in);
  wire rd_ok    = in_rx | in_stby;
  wire drain    = wr_ok & sf.rd_valid & mf.wr_ready & ~pend_q;
  wire host_pop = rd_req_in & rd_ok & mf.rd_valid;
  // Look-ahead staging count lets the ready output come from a flop without lagging
  wire [2:0] stage_nxt = sf.level + 3'(wr_valid_in & sf.wr_ready) - 3'(drain);

  // Transmit side
  wire       tx_tick   = bit_tick & in_tx;
  wire       sr_free   = (tx_bits_q == 4'h0) & ~pop_pend_q;
  wire       tx_start  = tx_start_sel_in ? nempty : (packet_mode_in ? thr : full);
  wire [7:0] fix_len   = len_clamp(payload_len_in, 1'b0, FIX_MIN_LEN, lim);
  wire       var_first = pkt_var_len_in & (tx_cnt_q == 8'h00);
  wire       pkt_left  = var_first | (tx_cnt_q < tx_tgt_q);
  wire       tx_want   = packet_mode_in ? pkt_left : 1'b1;
  wire       in_pay    = in_tx & sr_free & (phase_q == TX_PAY);
  wire       tx_pop    = in_pay & tx_want & nempty;
  wire       done_set  = in_pay & (packet_mode_in ? ~pkt_left : ~nempty);

  wire irq0_d = in_rx   ? irq_pick(irq0_sel_in, rx_push, nempty, sync_hit) :
                in_stby ? irq_pick(irq0_sel_in, 1'b0, nempty, 1'b0) :
                in_tx & nempty;
  wire irq1_d = in_rx   ? irq_pick(irq1_sel_in, full, ls[2], thr_src) :
                in_stby ? irq_pick(irq1_sel_in, full, 1'b0, thr_src) :
                in_tx & (tx_irq1_sel_in ? tx_done_q : full);

  assign sf.wr_valid   = wr_valid_in;
  assign sf.wr_data    = wr_data_in;
  assign sf.rd_ready   = drain;
  assign mf.wr_valid   = pend_q | rx_push;
  assign mf.wr_data    = pend_q ? sf.rd_data : rx_next;
  assign mf.rd_ready   = host_pop | tx_pop;
  assign rd_data_out   = mf.rd_data;

  // The staging buffer absorbs host bursts while the main store is busy or full
  fpim_fifo #(.W(BYTE_W), .DEPTH(STAGE_DEPTH), .AW(STAGE_AW)) u_stage (
    .clk_in   (core_clk_in),
    .rstn_in  (rstn_in),
    .limit_in (STAGE_LIMIT),
    .f        (sf)
  );

  fpim_fifo #(.W(BYTE_W), .DEPTH(FIFO_DEPTH), .AW(FIFO_AW)) u_store (
    .clk_in   (core_clk_in),
    .rstn_in  (rstn_in),
    .limit_in (lim),
    .f        (mf)
  );

  always_ff @(posedge core_clk_in) begin
    if (!rstn_in) begin
      lclk_q         <= 1'b0;
      pend_q         <= 1'b0;
      wr_ready_out   <= 1'b1;
      rd_valid_out   <= 1'b0;
      irq0_out       <= 1'b0;
      irq1_out       <= 1'b0;
      sync_en_out    <= 1'b0;
      bitsync_en_out <= 1'b0;
    end else begin
      lclk_q         <= ls[0];
      pend_q         <= drain;
      wr_ready_out   <= stage_nxt < STAGE_LIMIT;
      rd_valid_out   <= host_pop;
      irq0_out       <= irq0_d;
      irq1_out       <= irq1_d;
      sync_en_out    <= sync_en;
      bitsync_en_out <= 1'b1;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (!rstn_in) begin
      overrun_out <= 1'b0;
    end else if (rx_ovr) begin
      overrun_out <= 1'b1;
    end else if (overrun_clr_in) begin
      overrun_out <= 1'b0;
    end
  end

  // Stored bytes survive a mode change; the bit count, sync flag, packet byte count and length target are dropped
  always_ff @(posedge core_clk_in) begin
    if (!rstn_in) begin
      rx_sr_q     <= 8'h00;
      rx_bits_q   <= 3'h0;
      sync_seen_q <= 1'b0;
    end else if (!in_rx) begin
      rx_bits_q   <= 3'h0;
      sync_seen_q <= 1'b0;
    end else if (rx_tick) begin
      rx_sr_q <= rx_next;
      if (sync_hit) begin
        sync_seen_q <= 1'b1;
        rx_bits_q   <= 3'h0;
      end else if (capturing) begin
        rx_bits_q <= rx_bits_q + 3'h1;
      end
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (!rstn_in || !in_rx) begin
      rx_cnt_q <= 8'h00;
      rx_tgt_q <= 8'h00;
    end else if (sync_hit) begin
      rx_cnt_q <= 8'h00;
      rx_tgt_q <= pkt_var_len_in ? VAR_MIN_LEN : fix_len;
    end else if (rx_push) begin
      rx_cnt_q <= rx_cnt_q + 8'h01;
      if (pkt_var_len_in && rx_cnt_q == 8'h00) begin
        rx_tgt_q <= len_clamp(rx_next, 1'b1, VAR_MIN_LEN, lim);
      end
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (!rstn_in || !in_tx) begin
      phase_q   <= TX_IDLE;
      pre_cnt_q <= 8'h00;
      tx_tgt_q  <= 8'h00;
    end else begin
      unique case (phase_q)
        TX_IDLE: begin
          if (tx_start) begin
            phase_q   <= packet_mode_in ? TX_PRE : TX_PAY;
            pre_cnt_q <= PRE_COUNT;
            tx_tgt_q  <= fix_len;
          end
        end
        TX_PRE: begin
          if (sr_free) begin
            pre_cnt_q <= pre_cnt_q - 8'h01;
            if (pre_cnt_q <= 8'h01) begin
              phase_q <= TX_SYNC;
            end
          end
        end
        TX_SYNC: begin
          if (sr_free) begin
            phase_q <= TX_PAY;
          end
        end
        TX_PAY: begin
          if (pop_pend_q && var_first) begin
            tx_tgt_q <= len_clamp(mf.rd_data, 1'b1, VAR_MIN_LEN, lim);
          end
          if (packet_mode_in && done_set) begin
            phase_q <= TX_END;
          end
        end
        TX_END: begin
          phase_q <= TX_END;
        end
        default: begin
          phase_q <= TX_IDLE;
        end
      endcase
    end
  end

  // Leaving transmit cuts the bit stream at once, even mid-byte
  always_ff @(posedge core_clk_in) begin
    if (!rstn_in || !in_tx) begin
      tx_sr_q     <= 8'h00;
      tx_bits_q   <= 4'h0;
      pop_pend_q  <= 1'b0;
      tx_cnt_q    <= 8'h00;
      tx_data_out <= 1'b0;
    end else begin
      pop_pend_q <= tx_pop;
      if (pop_pend_q) begin
        tx_sr_q   <= mf.rd_data;
        tx_bits_q <= BITS_PER_BYTE;
        tx_cnt_q  <= tx_cnt_q + 8'h01;
      end else if (sr_free && phase_q == TX_PRE) begin
        tx_sr_q   <= PREAMBLE_BYTE;
        tx_bits_q <= BITS_PER_BYTE;
      end else if (sr_free && phase_q == TX_SYNC) begin
        tx_sr_q   <= sync_pattern_in;
        tx_bits_q <= BITS_PER_BYTE;
      end else if (tx_tick && tx_bits_q != 4'h0) begin
        tx_data_out <= tx_sr_q[7];
        tx_sr_q     <= {tx_sr_q[6:0], 1'b0};
        tx_bits_q   <= tx_bits_q - 4'h1;
      end
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (!rstn_in || !in_tx) begin
      tx_done_q <= 1'b0;
    end else if (done_set) begin
      tx_done_q <= 1'b1;
    end else if (tx_pop) begin
      tx_done_q <= 1'b0;
    end
  end

  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (!rstn_in);

  irq0_nempty_a: assert property (in_rx && irq0_sel_in == SEL_B |=> irq0_out == $past(nempty))
    else $error("line 0 does not follow nonempty in receive");
  irq1_stby_a: assert property (in_stby && irq1_sel_in == SEL_B |=> !irq1_out)
    else $error("RSSI reached line 1 in standby");
  irq1_txdone_a: assert property (in_tx && tx_irq1_sel_in |=> irq1_out == $past(tx_done_q))
    else $error("line 1 does not follow transmit done");
  tx_start_a: assert property (in_tx && tx_start_sel_in && !packet_mode_in && phase_q == TX_IDLE
                               && nempty ##1 in_tx |-> phase_q == TX_PAY)
    else $error("transmit did not start on first byte");
  thr_gate_a: assert property (in_rx && !fill_method_in && !sync_seen_q && irq1_sel_in == SEL_C
                               |=> !irq1_out)
    else $error("threshold raised before sync");
  rx_drop_a: assert property (!in_rx |=> rx_bits_q == 3'h0 && !sync_seen_q)
    else $error("partial byte kept after leaving receive");
  sync_force_a: assert property (packet_mode_in |=> sync_en_out && bitsync_en_out)
    else $error("sync not forced in packet mode");
  stby_drain_a: assert property (in_stby && !packet_mode_in |-> !drain)
    else $error("store written in buffered standby");
  pay_limit_a: assert property (packet_mode_in && phase_q == TX_PAY && !var_first
                                |-> tx_tgt_q <= {1'b0, lim} && tx_tgt_q != 8'h00)
    else $error("payload length outside limits");
  done_gap_a: assert property ($rose(tx_done_q) |-> tx_bits_q == 4'h0 && !pop_pend_q)
    else $error("done raised with bits left");
  overrun_a: assert property (rx_ovr |=> overrun_out ##1 overrun_out || $past(overrun_clr_in))
    else $error("overrun not flagged");

  sync_seen_c: cover property (sync_hit ##1 sync_seen_q);
  tx_done_c:   cover property ($rose(tx_done_q));
  overrun_c:   cover property (rx_ovr);
  pkt_end_c:   cover property (phase_q == TX_PAY ##1 phase_q == TX_END);
endmodule : fpim_top

// ==== sim/fpim_link_model.sv ====
`timescale 1ns/10ps
module fpim_link_model (
  output logic link_clk_out,
  output logic rx_data_out
);
  initial begin
    link_clk_out = 1'b0;
    rx_data_out  = 1'b1;
  end

  // One bit per 80 ns period; the clock stands still between frames
  task automatic bit_out(input logic b);
    rx_data_out = b;
    #40;
    link_clk_out = 1'b1;
    #40;
    link_clk_out = 1'b0;
  endtask : bit_out

  // Sends the top n bits MSB first, then leaves the line at the inverse
  task automatic send_bits(input logic [7:0] v, input int n);
    #2;
    for (int i = 7; i > 7 - n; i--) begin
      bit_out(v[i]);
    end
    rx_data_out = ~v[8-n];
  endtask : send_bits

  // Bit clock for transmit; data line toggles so no stale level survives
  // Starts just off the core clock edge so the pins never race the sampling flop
  task automatic run_clock(input int n);
    #2;
    for (int i = 0; i < n; i++) begin
      bit_out(~rx_data_out);
    end
  endtask : run_clock
endmodule : fpim_link_model

// ==== sim/fpim_top_bench.sv ====
`timescale 1ns/10ps
module fpim_top_bench;
  import fpim_pkg::*;
  localparam logic [7:0] PRE_N  = 8'h02;
  localparam logic [7:0] SYNC_W = 8'hD3;
  logic       core_clk_in, rstn_in, packet_mode_in, sync_on_in, tx_irq1_sel_in;
  logic       tx_start_sel_in, fill_method_in, fill_in, pkt_var_len_in, overrun_clr_in;
  logic       link_clk_in, rx_data_in, rssi_in, wr_valid_in, rd_req_in;
  logic       wr_ready_out, rd_valid_out, tx_data_out, irq0_out, irq1_out;
  logic       overrun_out, sync_en_out, bitsync_en_out;
  fpim_mode_t mode_in;
  logic [1:0] fifo_size_in, irq0_sel_in, irq1_sel_in;
  logic [5:0] fifo_thresh_in;
  logic [7:0] payload_len_in, sync_pattern_in, wr_data_in, rd_data_out, sh, d;
  logic       saw0, tx_on, hunt;
  logic [7:0] exp_rd[$];
  logic [7:0] exp_tx[$];
  int         errors, total_checks, nb, nrd, seed;

  fpim_top #(.PRE_COUNT(PRE_N)) i_fpim_top (
    .core_clk_in(core_clk_in), .rstn_in(rstn_in), .mode_in(mode_in),
    .packet_mode_in(packet_mode_in), .sync_on_in(sync_on_in), .fifo_size_in(fifo_size_in),
    .fifo_thresh_in(fifo_thresh_in), .irq0_sel_in(irq0_sel_in), .irq1_sel_in(irq1_sel_in),
    .tx_irq1_sel_in(tx_irq1_sel_in), .tx_start_sel_in(tx_start_sel_in),
    .fill_method_in(fill_method_in), .fill_in(fill_in), .pkt_var_len_in(pkt_var_len_in),
    .payload_len_in(payload_len_in), .sync_pattern_in(sync_pattern_in),
    .overrun_clr_in(overrun_clr_in), .link_clk_in(link_clk_in), .rx_data_in(rx_data_in),
    .rssi_in(rssi_in), .wr_valid_in(wr_valid_in), .wr_data_in(wr_data_in),
    .wr_ready_out(wr_ready_out), .rd_req_in(rd_req_in), .rd_valid_out(rd_valid_out),
    .rd_data_out(rd_data_out), .tx_data_out(tx_data_out), .irq0_out(irq0_out),
    .irq1_out(irq1_out), .overrun_out(overrun_out), .sync_en_out(sync_en_out),
    .bitsync_en_out(bitsync_en_out));

  fpim_link_model i_fpim_link_model (.link_clk_out(link_clk_in), .rx_data_out(rx_data_in));

  initial begin
    core_clk_in = 1'b0;
    forever #5 core_clk_in = ~core_clk_in;
  end

  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    total_checks++;
    if (g !== e) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk_in);
  endtask : cyc

  // Request held until ready is seen high at the taking edge
  task automatic wr(input logic [7:0] b);
    int n;
    n = 0;
    @(posedge core_clk_in);
    wr_valid_in <= 1'b1;
    wr_data_in  <= b;
    @(negedge core_clk_in);
    while (wr_ready_out !== 1'b1 && n < 50) begin
      @(negedge core_clk_in);
      n++;
    end
    if (n >= 50) chk("wr_timeout", 8'h00, 8'h01);
    @(posedge core_clk_in);
    wr_valid_in <= 1'b0;
  endtask : wr

  task automatic stop_test;
    if (errors == 0 && total_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : stop_test

  // Read results: oldest note is compared against each popped byte
  always @(negedge core_clk_in) begin
    if (irq0_out === 1'b1) saw0 = 1'b1;
    if (rstn_in === 1'b1 && rd_valid_out === 1'b1) begin
      nrd++;
      if (exp_rd.size() == 0) chk("rd_extra", 8'h00, rd_data_out);
      else chk("rd_data", exp_rd.pop_front(), rd_data_out);
    end
  end

  // Transmit results: frame starts at the first high bit, MSB first
  always @(posedge link_clk_in) begin
    if (tx_on && !hunt && tx_data_out === 1'b1 && exp_tx.size() > 0) begin
      hunt = 1'b1;
      nb   = 0;
    end
    if (tx_on && hunt) begin
      sh = {sh[6:0], tx_data_out};
      nb++;
      if (nb == 8) begin
        chk("tx_byte", exp_tx.pop_front(), sh);
        nb = 0;
        if (exp_tx.size() == 0) hunt = 1'b0;
      end
    end
  end

  initial begin
    seed = 32'hc89e;
    {saw0, tx_on, hunt, nb, nrd, errors, total_checks} = '0;
    rstn_in = 1'b0;
    mode_in = M_SLEEP;
    {packet_mode_in, sync_on_in, tx_irq1_sel_in, tx_start_sel_in} = 4'h0;
    {fill_method_in, fill_in, pkt_var_len_in, overrun_clr_in, rssi_in} = 5'h00;
    {wr_valid_in, rd_req_in, fifo_size_in, irq0_sel_in, irq1_sel_in} = 8'h00;
    fifo_thresh_in  = 6'h02;
    payload_len_in  = 8'h01;
    sync_pattern_in = SYNC_W;
    wr_data_in      = 8'h00;
    sh              = 8'h00;
    cyc(5);
    rstn_in <= 1'b1;
    cyc(3);
    @(negedge core_clk_in);
    chk("wr_ready", 8'h01, wr_ready_out);
    @(posedge core_clk_in);
    mode_in     <= M_RX;
    sync_on_in  <= 1'b1;
    irq0_sel_in <= SEL_C;
    irq1_sel_in <= SEL_C;
    cyc(4);
    saw0 = 1'b0;
    i_fpim_link_model.send_bits(SYNC_W, 8);
    cyc(8);
    chk("irq0_sync", 8'h01, saw0);
    for (int i = 0; i < 2; i++) begin
      d = $random(seed);
      exp_rd.push_back(d);
      chk("irq1_thresh", 8'h00, irq1_out);
      i_fpim_link_model.send_bits(d, 8);
      cyc(8);
    end
    chk("irq1_thresh", 8'h01, irq1_out);
    @(posedge core_clk_in);
    irq0_sel_in <= SEL_B;
    cyc(3);
    chk("irq0_nonempty", 8'h01, irq0_out);
    i_fpim_link_model.send_bits(8'hF0, 4);
    cyc(8);
    @(posedge core_clk_in);
    mode_in <= M_STBY;
    cyc(4);
    chk("stby_irq1", 8'h01, irq1_out);
    chk("stby_irq0", 8'h01, irq0_out);
    for (int n = 0; n < 8 && irq0_out === 1'b1; n++) begin
      @(posedge core_clk_in);
      rd_req_in <= 1'b1;
      @(posedge core_clk_in);
      rd_req_in <= 1'b0;
      cyc(4);
    end
    chk("rd_count", 8'h02, 8'(nrd));
    chk("irq1_low", 8'h00, irq1_out);
    @(posedge core_clk_in);
    mode_in         <= M_TX;
    tx_start_sel_in <= 1'b1;
    tx_irq1_sel_in  <= 1'b1;
    cyc(3);
    chk("done_early", 8'h00, irq1_out);
    d = $random(seed);
    d = d | 8'h80;
    exp_tx.push_back(d);
    tx_on = 1'b1;
    wr(d);
    i_fpim_link_model.run_clock(14);
    chk("tx_done", 8'h01, irq1_out);
    chk("tx_irq0", 8'h00, irq0_out);
    i_fpim_link_model.run_clock(1);
    @(posedge core_clk_in);
    mode_in        <= M_STBY;
    packet_mode_in <= 1'b1;
    pkt_var_len_in <= 1'b1;
    tx_on = 1'b0;
    hunt  = 1'b0;
    chk("tx_left", 8'h00, 8'(exp_tx.size()));
    cyc(3);
    d = $random(seed);
    wr(8'h01);
    wr(d);
    exp_tx = '{8'hAA, 8'hAA, SYNC_W, 8'h01, d};
    cyc(6);
    chk("sync_en", 8'h01, sync_en_out);
    chk("bitsync_en", 8'h01, bitsync_en_out);
    tx_on = 1'b1;
    @(posedge core_clk_in);
    mode_in <= M_TX;
    i_fpim_link_model.run_clock(46);
    chk("pkt_left", 8'h00, 8'(exp_tx.size()));
    chk("rd_left", 8'h00, 8'(exp_rd.size()));
    @(posedge core_clk_in);
    mode_in        <= M_RX;
    packet_mode_in <= 1'b0;
    irq0_sel_in    <= SEL_A;
    irq1_sel_in    <= SEL_B;
    rssi_in        <= 1'b1;
    cyc(8);
    chk("irq1_rssi", 8'h01, irq1_out);
    @(posedge core_clk_in);
    irq1_sel_in <= SEL_A;
    saw0 = 1'b0;
    i_fpim_link_model.send_bits(SYNC_W, 8);
    for (int i = 0; i < 17; i++) begin
      d = $random(seed);
      if (i < 16) exp_rd.push_back(d);
      cyc(1);
      i_fpim_link_model.send_bits(d, 8);
    end
    cyc(8);
    chk("irq0_byte", 8'h01, saw0);
    chk("irq1_full", 8'h01, irq1_out);
    chk("overrun", 8'h01, overrun_out);
    @(posedge core_clk_in);
    mode_in        <= M_STBY;
    irq0_sel_in    <= SEL_B;
    overrun_clr_in <= 1'b1;
    @(posedge core_clk_in);
    overrun_clr_in <= 1'b0;
    cyc(2);
    chk("overrun_clr", 8'h00, overrun_out);
    for (int n = 0; n < 20 && irq0_out === 1'b1; n++) begin
      @(posedge core_clk_in);
      rd_req_in <= 1'b1;
      @(posedge core_clk_in);
      rd_req_in <= 1'b0;
      cyc(4);
    end
    chk("rd_count", 8'h12, 8'(nrd));
    chk("rd_left", 8'h00, 8'(exp_rd.size()));
    @(posedge core_clk_in);
    packet_mode_in  <= 1'b1;
    pkt_var_len_in  <= 1'b0;
    payload_len_in  <= 8'h02;
    tx_start_sel_in <= 1'b0;
    cyc(3);
    d = $random(seed);
    wr(d);
    wr(~d);
    exp_tx = '{8'hAA, 8'hAA, SYNC_W, d, ~d};
    cyc(6);
    @(posedge core_clk_in);
    mode_in <= M_TX;
    i_fpim_link_model.run_clock(46);
    chk("fix_left", 8'h00, 8'(exp_tx.size()));
    stop_test();
  end
endmodule : fpim_top_bench
